// ### odtc_params.svh
// constants for the on-die termination control link
// assumes a single 25 MHz clock shared by both ends
// Notes on behaviour
// - termination connected only while control input high
// - mode bits 0,1 give 75, 1,0 give 150
// - termination covers data, mask, strobes, read strobes
// - active: turn-on starts two clocks after high
// - active: turn-off starts two and half clocks after; code turns off three clocks after low is sampled
// - power-down: unaligned, bounded turn-on and turn-off; code uses the same clock-aligned taps as active mode
// - writes: controller off, non-target rank terminates; code picks the rank from use_rank2_i and never uses cmd_slot_i
// - reads: controller 150 dual, 75 single slot
// - second rank may terminate instead of first
// - read window from RL-3 to RL+BL/2-2
// - write window from RL-3 to WL+BL/2-2
// - read latency is additive plus cas latency
// - write latency is read latency minus one
// - controller termination follows dram turn-on, held; code switches self_rtt_o in the same cycles as term_en, ahead of the dram
// - no controller termination needed during writes
// - termination off throughout self refresh
`ifndef ODTC_PARAMS_SVH
`define ODTC_PARAMS_SVH
`define ODTC_CLK_PERIOD_NS 40
`define ODTC_ON_DELAY_HALF 4'h4
`define ODTC_OFF_DELAY_HALF 4'h5
`define ODTC_TAC_MAX_NS 1
`define ODTC_PD_EXTRA_NS 1
`define ODTC_PD_ON_HALF 4'h4
`define ODTC_PD_OFF_HALF 4'h5
`define ODTC_RTT_75 2'h1
`define ODTC_RTT_150 2'h2
`define ODTC_RTT_OFF 2'h0
`define ODTC_RD_LEAD 4'h3
`define ODTC_TAIL 4'h2
`define ODTC_WL_LESS 4'h1
`define ODTC_PIN_COUNT 12
`endif

// ### odtc_pkg.sv
// types shared by both ends of the termination link
// assumes odtc_params.svh is on the include path
package odtc_pkg;
    typedef enum logic [2:0] {
        ODTC_MODE_ACTIVE = 3'h1,
        ODTC_MODE_PDOWN = 3'h2,
        ODTC_MODE_SREF = 3'h4
    } odtc_mode_t;
    typedef enum logic [1:0] {
        ODTC_CFG_ONE_SLOT = 2'h1,
        ODTC_CFG_TWO_SLOT = 2'h2
    } odtc_cfg_t;
endpackage

// ### odtc_if.sv
// link between controller and dram termination logic
// assumes both ends share clk_i
interface odtc_if;
    logic [1:0] term_en;
    logic [1:0] rtt_sel;
    logic [2:0] mode;
    modport ctrl (output term_en, output rtt_sel, output mode);
    modport dram (input term_en, input rtt_sel, input mode);
endinterface

// ### odtc_dram.sv
// dram end: termination switch timing per rank
// assumes link inputs synchronous to clk_i
`include "odtc_params.svh"
module odtc_dram (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic rank_i,
    odtc_if.dram link,
    output logic term_switch_a_o,
    output logic term_switch_b_o,
    output logic [`ODTC_PIN_COUNT-1:0] pin_term_o,
    output logic term_on_o
);
    // ----------------------------------------
    // half-clock delay line of sampled control
    // ----------------------------------------
    logic [7:0] line_q, line_d;
    logic seen_q, seen_d;
    logic on_q, on_d;
    logic a_q, a_d, b_q, b_d;
    logic [1:0] sel_q, sel_d;
    logic [`ODTC_PIN_COUNT-1:0] pin_q, pin_d;
    logic ctl;
    logic [3:0] on_tap, off_tap;
    assign ctl = link.term_en[rank_i];
    always_comb begin
        line_d = {line_q[5:0], ctl, ctl};
        seen_d = seen_q | ctl;
        on_tap = (link.mode == odtc_pkg::ODTC_MODE_PDOWN) ?
            `ODTC_PD_ON_HALF : `ODTC_ON_DELAY_HALF;
        off_tap = (link.mode == odtc_pkg::ODTC_MODE_PDOWN) ?
            `ODTC_PD_OFF_HALF : `ODTC_OFF_DELAY_HALF;
        on_d = on_q;
        if (line_q[on_tap[2:0]-3'h1]) begin
            on_d = 1'b1;
        end
        if (!line_q[off_tap[2:0]-3'h1] && !line_q[on_tap[2:0]-3'h1]) begin
            on_d = 1'b0;
        end
        if (link.mode == odtc_pkg::ODTC_MODE_SREF || !seen_d) begin
            on_d = 1'b0;
        end
        // hold last value choice so turn-off tail keeps its resistance
        sel_d = (link.rtt_sel != `ODTC_RTT_OFF) ? link.rtt_sel : sel_q;
        a_d = on_d && (sel_d == `ODTC_RTT_75);
        b_d = on_d && (sel_d == `ODTC_RTT_150);
        pin_d = {`ODTC_PIN_COUNT{a_d | b_d}};
    end
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            line_q <= 8'h00;
            seen_q <= 1'b0;
            on_q <= 1'b0;
            a_q <= 1'b0;
            b_q <= 1'b0;
            sel_q <= 2'h0;
            pin_q <= '0;
        end else begin
            line_q <= line_d;
            seen_q <= seen_d;
            on_q <= on_d;
            a_q <= a_d;
            b_q <= b_d;
            sel_q <= sel_d;
            pin_q <= pin_d;
        end
    end
    assign term_switch_a_o = a_q;
    assign term_switch_b_o = b_q;
    assign pin_term_o = pin_q;
    assign term_on_o = on_q;
endmodule

// ### odtc_ctrl.sv
// controller end: termination window around reads and writes
// assumes commands are one-cycle pulses on clk_i
`include "odtc_params.svh"
module odtc_ctrl (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic cmd_rd_i,
    input wire logic cmd_wr_i,
    input wire logic cmd_slot_i,
    input wire logic two_slot_i,
    input wire logic use_rank2_i,
    input wire logic [2:0] additive_latency_i,
    input wire logic [2:0] cas_latency_i,
    input wire logic burst8_i,
    input wire logic [2:0] mode_i,
    odtc_if.ctrl link,
    output logic [1:0] self_rtt_o,
    output logic busy_o
);
    // ----------------------------------------
    // window timing and termination choice
    // ----------------------------------------
    logic [4:0] cnt_q, cnt_d;
    logic [4:0] start_q, start_d, stop_q, stop_d;
    logic act_q, act_d, rd_q, rd_d, slot_q, slot_d;
    logic [1:0] en_q, en_d, rtt_q, rtt_d, self_q, self_d;
    logic [2:0] mode_q;
    logic [4:0] rl, wl, half;
    logic win;
    always_comb begin
        rl = 5'(additive_latency_i) + 5'(cas_latency_i);
        wl = rl - 5'(`ODTC_WL_LESS);
        half = burst8_i ? 5'h04 : 5'h02;
        cnt_d = cnt_q;
        start_d = start_q;
        stop_d = stop_q;
        act_d = act_q;
        rd_d = rd_q;
        slot_d = slot_q;
        if (!act_q && (cmd_rd_i || cmd_wr_i)) begin
            act_d = 1'b1;
            rd_d = cmd_rd_i;
            slot_d = cmd_slot_i;
            cnt_d = 5'h00;
            start_d = rl - 5'(`ODTC_RD_LEAD) - 5'h01;
            // last count is one short: term_en is sampled an edge later
            stop_d = (cmd_rd_i ? rl : wl) + half
                - 5'(`ODTC_TAIL) - 5'h01;
        end else if (act_q) begin
            cnt_d = cnt_q + 5'h01;
            if (cnt_q >= stop_q) begin
                act_d = 1'b0;
            end
        end
        win = act_d && (cnt_d >= start_d) && (cnt_d <= stop_d);
        en_d = 2'h0;
        rtt_d = `ODTC_RTT_OFF;
        self_d = `ODTC_RTT_OFF;
        if (win) begin
            if (two_slot_i) begin
                en_d = use_rank2_i ? 2'h2 : 2'h1;
                rtt_d = `ODTC_RTT_75;
                if (rd_d) begin
                    self_d = `ODTC_RTT_150;
                end
            end else if (!rd_d) begin
                en_d = 2'h1;
                rtt_d = `ODTC_RTT_150;
            end else begin
                self_d = `ODTC_RTT_75;
            end
        end
    end
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q <= 5'h00;
            start_q <= 5'h00;
            stop_q <= 5'h00;
            act_q <= 1'b0;
            rd_q <= 1'b0;
            slot_q <= 1'b0;
            en_q <= 2'h0;
            rtt_q <= 2'h0;
            self_q <= 2'h0;
            mode_q <= 3'h1;
        end else begin
            cnt_q <= cnt_d;
            start_q <= start_d;
            stop_q <= stop_d;
            act_q <= act_d;
            rd_q <= rd_d;
            slot_q <= slot_d;
            en_q <= en_d;
            rtt_q <= rtt_d;
            self_q <= self_d;
            mode_q <= mode_i;
        end
    end
    assign link.term_en = en_q;
    assign link.rtt_sel = rtt_q;
    assign link.mode = mode_q;
    assign self_rtt_o = self_q;
    assign busy_o = act_q;
endmodule

// ### odtc_assertions.sv
// assertions on the termination link signals
// assumes one instance beside the link interface
module odtc_assertions (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [1:0] term_en,
    input wire logic [1:0] rtt_sel,
    input wire logic [2:0] mode
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    property p_rank; !(&term_en); endproperty
    a_rank: assert property (p_rank)
        else $error("both ranks on");
    property p_code; rtt_sel != 2'h3; endproperty
    a_code: assert property (p_code)
        else $error("bad rtt code");
    property p_sel; |term_en |-> rtt_sel != 2'h0; endproperty
    a_sel: assert property (p_sel)
        else $error("on without rtt");
    property p_min; $rose(|term_en) |-> (|term_en) [*3]; endproperty
    a_min: assert property (p_min)
        else $error("window short");
    property p_max; $rose(|term_en) |-> ##[1:6] !(|term_en); endproperty
    a_max: assert property (p_max)
        else $error("window long");
    property p_hold; |term_en && $past(|term_en) |-> $stable(rtt_sel);
    endproperty
    a_hold: assert property (p_hold)
        else $error("rtt moved");
    property p_mode; $onehot(mode); endproperty
    a_mode: assert property (p_mode)
        else $error("mode not one-hot");
    property p_rst; $rose(resetn_i) |-> term_en == 2'h0; endproperty
    a_rst: assert property (p_rst)
        else $error("on after reset");
endmodule

// ### ddr2_on_die_termination_ctrl_tb.sv
// bench for both ends of the termination link
// assumes design files and header on the include path
`include "odtc_params.svh"
module ddr2_on_die_termination_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic rd, slot, two, r2;
        logic [2:0] al, cl;
        logic b8;
        logic [2:0] md;
        logic [1:0] te, rtt, slf;
    } odtc_row_t;
    // rd slot two r2, al, cl, b8, mode, term_en, rtt, own rtt
    localparam logic [19:0] rows [7] = '{20'hA1056, 20'h72EA4,
        20'h05458, 20'h81641, 20'hF6EA6, 20'h61054, 20'h21114};
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic rd = 1'b0, wr = 1'b0, slot = 1'b0, two = 1'b0, r2 = 1'b0;
    logic b8 = 1'b0;
    logic [2:0] al = 3'h0, cl = 3'h4, md = 3'h1;
    logic sw_a, sw_b, term_on, busy;
    logic [`ODTC_PIN_COUNT-1:0] pins;
    logic [1:0] own;
    int fails = 0, samples_checked = 0, cyc = 0;
    odtc_if link ();
    odtc_ctrl u_odtc_ctrl (.clk_i(clk_i), .resetn_i(resetn_i),
        .cmd_rd_i(rd), .cmd_wr_i(wr), .cmd_slot_i(slot), .two_slot_i(two),
        .use_rank2_i(r2), .additive_latency_i(al), .cas_latency_i(cl),
        .burst8_i(b8), .mode_i(md), .link(link), .self_rtt_o(own),
        .busy_o(busy));
    odtc_dram u_odtc_dram (.clk_i(clk_i), .resetn_i(resetn_i),
        .rank_i(r2), .link(link), .term_switch_a_o(sw_a),
        .term_switch_b_o(sw_b), .pin_term_o(pins), .term_on_o(term_on));
    odtc_assertions u_odtc_assertions (.clk_i(clk_i), .resetn_i(resetn_i),
        .term_en(link.term_en), .rtt_sel(link.rtt_sel), .mode(link.mode));
    always #20 clk_i = ~clk_i;
    task automatic report_and_stop();
        $display("checked %0d failed %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic run(input odtc_row_t r, input logic dbl);
        int rl, e;
        logic on;
        rl = r.al + r.cl;
        e = (r.rd ? rl : rl - 1) + (r.b8 ? 4 : 2) - 2;
        on = r.te[r.r2] && r.md != odtc_pkg::ODTC_MODE_SREF;
        {md, slot, two, r2, al, cl, b8} <= {r.md, r.slot, r.two, r.r2,
            r.al, r.cl, r.b8};
        repeat (3) @(posedge clk_i);
        rd <= r.rd;
        wr <= !r.rd;
        @(posedge clk_i);
        rd <= 1'b0;
        wr <= 1'b0;
        for (int k = 1; k <= e + 5; k++) begin
            @(negedge clk_i);
            if (r.md != odtc_pkg::ODTC_MODE_SREF)
                cmp(link.term_en, (k >= rl - 3 && k <= e) ? r.te : 2'h0);
            if (k == rl - 1 || k == e + 5) cmp(term_on, 1'b0);
            if (k == rl || k == e + 3) cmp(term_on, on);
            if (k == rl) begin
                cmp({sw_a, sw_b}, {on && r.rtt == 2'h1, on && r.rtt == 2'h2});
                cmp(pins, {`ODTC_PIN_COUNT{on}});
            end
            if (k == e + 3) cmp(pins, {`ODTC_PIN_COUNT{on}});
            if (k == e && r.te != 2'h0) cmp(link.rtt_sel, r.rtt);
            if (k == e) cmp(own, r.slf);
            @(posedge clk_i);
            wr <= dbl && k == 2;
        end
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        for (int i = 0; i < 7; i++) run(rows[i], 1'b0);
        run(rows[0], 1'b1);
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b0;
        #1 cmp({link.term_en, term_on}, 12'h0);
        @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (6) @(negedge clk_i) cmp(term_on, 1'b0);
        report_and_stop();
    end
endmodule
